// ---- verilog/modbus_tcp_register_slave.sv ----
// frame server for register writes, single reads and pulse coils
`timescale 1ns/1ps
module modbus_tcp_register_slave #(
  parameter int unsigned SEC_CYCLES = mbtcp_pkg::SECOND_CYCLES,
  parameter logic [15:0] FW_VERSION = 16'h007B,
  // arbitrary identifier value
  parameter logic [15:0] MODULE_ID = 16'h1234,
  parameter logic [15:0] DOG_DEFAULT = 16'h000A,
  parameter logic [15:0] TCP_DEFAULT = 16'h00B4,
  parameter logic [15:0] SYS_DEFAULT = 16'h0078
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // request byte stream
  input wire mbtcp_pkg::byte_stream_type i_rx,
  output logic o_rx_ready,
  // reply byte stream
  output mbtcp_pkg::byte_stream_type o_tx,
  input wire logic i_tx_ready,
  // device status
  input wire logic [15:0] i_reset_cause,
  input wire logic [15:0] i_pair_status,
  // actions
  output logic o_restore_web,
  output logic o_restore_identity,
  output logic o_reboot,
  output logic o_flash_store,
  output logic o_safe_outputs,
  output logic o_tcp_idle_timeout,
  output logic o_system_timeout
);

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  mbtcp_pkg::state_type state_r;
  logic [3:0] idx_r, txi_r;
  logic [31:0] msg_r;
  logic [15:0] len_r, rem_r, addr_r, count_r, rdval_r;
  logic [7:0] station_r, fc_r, exc_r, err_r, hi_r, dcnt_r;
  logic ok_r, cap_done_r;
  logic [15:0] cause_r, dog_r, events_r, tcp_r, sys_r, comm_r;
  logic [31:0] pre_r;
  logic [15:0] idle_r;

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  function automatic logic hr_writable(input logic [15:0] a);
    hr_writable = (a == mbtcp_pkg::HR_RESET_CAUSE) ||
                  (a == mbtcp_pkg::HR_DOG_PERIOD) ||
                  (a == mbtcp_pkg::HR_DOG_EVENTS) ||
                  (a == mbtcp_pkg::HR_TCP_IDLE_TIMEOUT) ||
                  (a == mbtcp_pkg::HR_SYS_TIMEOUT);
  endfunction : hr_writable

  // 0 picks the default, below the minimum disables (returns 0)
  function automatic logic [15:0] effective(input logic [15:0] v,
      input logic [15:0] lo, input logic [15:0] dflt);
    if (v == 16'h0000) begin
      effective = dflt;
    end else if (v < lo) begin
      effective = 16'h0000;
    end else begin
      effective = v;
    end
  endfunction : effective

  // returns {hit, value} for single-register reads
  function automatic logic [16:0] read_reg(input logic [7:0] fc,
      input logic [15:0] a);
    read_reg = 17'h0_0000;
    if (fc == mbtcp_pkg::FC_READ_INPUT) begin
      unique case (a)
        mbtcp_pkg::IR_FW_VERSION: read_reg = {1'b1, FW_VERSION};
        mbtcp_pkg::IR_COMM_STATUS: read_reg = {1'b1, comm_r};
        mbtcp_pkg::IR_PAIR_STATUS: read_reg = {1'b1, i_pair_status};
        default: read_reg = 17'h0_0000;
      endcase
    end else begin
      unique case (a)
        mbtcp_pkg::HR_RESET_CAUSE: read_reg = {1'b1, cause_r};
        mbtcp_pkg::HR_DOG_PERIOD: read_reg = {1'b1, dog_r};
        mbtcp_pkg::HR_DOG_EVENTS: read_reg = {1'b1, events_r};
        mbtcp_pkg::HR_MODULE_ID: read_reg = {1'b1, MODULE_ID};
        mbtcp_pkg::HR_TCP_IDLE_TIMEOUT: read_reg = {1'b1, tcp_r};
        mbtcp_pkg::HR_SYS_TIMEOUT: read_reg = {1'b1, sys_r};
        default: read_reg = 17'h0_0000;
      endcase
    end
  endfunction : read_reg

  // checked once the byte count arrives, before any value is stored
  function automatic logic [7:0] write_check(input logic [7:0] fc,
      input logic [15:0] a, input logic [15:0] cnt, input logic [7:0] bc,
      input logic [15:0] len);
    logic [15:0] need;
    need = mbtcp_pkg::WRITE_FIXED_LEN + {8'h00, bc};
    write_check = mbtcp_pkg::EXC_NONE;
    if (fc == mbtcp_pkg::FC_WRITE_REGS) begin
      if (cnt == 16'h0000 || cnt > mbtcp_pkg::MAX_WRITE_REGS ||
          {8'h00, bc} != {cnt[14:0], 1'b0} || len != need) begin
        write_check = mbtcp_pkg::EXC_VALUE;
      end else if (!hr_writable(a) || (cnt != 16'h0001 &&
          (cnt != 16'h0002 || !hr_writable(a + 16'h0001)))) begin
        write_check = mbtcp_pkg::EXC_ADDR;
      end
    end else begin
      if (cnt != 16'h0001 || bc != 8'h01 || len != need) begin
        write_check = mbtcp_pkg::EXC_VALUE;
      end else if (a != mbtcp_pkg::COIL_RESTORE_WEB &&
          a != mbtcp_pkg::COIL_RESTORE_ID && a != mbtcp_pkg::COIL_REBOOT) begin
        write_check = mbtcp_pkg::EXC_ADDR;
      end
    end
  endfunction : write_check

  // -------------------------------------------------------------------
  // receive decode
  // -------------------------------------------------------------------
  logic take, frame_end, is_read, is_write, station_ok;
  logic [15:0] cnt_full;
  logic [7:0] err_nxt, exc_nxt;
  logic [16:0] rd_hit;
  logic [3:0] tx_last;

  assign take = i_rx.valid && o_rx_ready;
  assign frame_end = take && idx_r >= mbtcp_pkg::IDX_STATION &&
                     rem_r == 16'h0001;
  assign is_read = fc_r == mbtcp_pkg::FC_READ_HOLD ||
                   fc_r == mbtcp_pkg::FC_READ_INPUT;
  assign is_write = fc_r == mbtcp_pkg::FC_WRITE_REGS ||
                    fc_r == mbtcp_pkg::FC_WRITE_COILS;
  assign station_ok = station_r >= mbtcp_pkg::STATION_MIN &&
                      station_r <= mbtcp_pkg::STATION_MAX;
  // the count low byte lands on the edge that ends a read frame
  assign cnt_full = (take && idx_r == mbtcp_pkg::IDX_CNT_LO) ?
      {count_r[15:8], i_rx.data} : count_r;
  assign err_nxt = (take && idx_r == mbtcp_pkg::IDX_BCNT) ?
      write_check(fc_r, addr_r, cnt_full, i_rx.data, len_r) : err_r;
  assign rd_hit = read_reg(fc_r, addr_r);

  always_comb begin
    if (!is_read && !is_write) begin
      exc_nxt = mbtcp_pkg::EXC_FUNC;
    end else if (is_read) begin
      if (cnt_full != 16'h0001 || len_r != mbtcp_pkg::READ_PDU_LEN) begin
        exc_nxt = mbtcp_pkg::EXC_VALUE;
      end else begin
        exc_nxt = rd_hit[16] ? mbtcp_pkg::EXC_NONE : mbtcp_pkg::EXC_ADDR;
      end
    end else begin
      exc_nxt = err_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      idx_r <= 4'h0;
      msg_r <= 32'h0000_0000;
      len_r <= 16'h0000;
      rem_r <= 16'h0000;
      station_r <= 8'h00;
      fc_r <= 8'h00;
      addr_r <= 16'h0000;
      count_r <= 16'h0000;
      err_r <= mbtcp_pkg::EXC_VALUE;
      ok_r <= 1'b0;
      hi_r <= 8'h00;
      dcnt_r <= 8'h00;
    end else if (take) begin
      if (idx_r < mbtcp_pkg::IDX_DATA) begin
        idx_r <= idx_r + 4'h1;
      end
      unique case (idx_r)
        mbtcp_pkg::IDX_LEN_HI: len_r[15:8] <= i_rx.data;
        mbtcp_pkg::IDX_LEN_LO: begin
          len_r[7:0] <= i_rx.data;
          rem_r <= {len_r[15:8], i_rx.data};
          if ({len_r[15:8], i_rx.data} == 16'h0000) begin
            idx_r <= 4'h0;
          end
        end
        mbtcp_pkg::IDX_STATION: station_r <= i_rx.data;
        mbtcp_pkg::IDX_FC: fc_r <= i_rx.data;
        mbtcp_pkg::IDX_ADDR_HI: addr_r[15:8] <= i_rx.data;
        mbtcp_pkg::IDX_ADDR_LO: addr_r[7:0] <= i_rx.data;
        mbtcp_pkg::IDX_CNT_HI: count_r[15:8] <= i_rx.data;
        mbtcp_pkg::IDX_CNT_LO: count_r[7:0] <= i_rx.data;
        mbtcp_pkg::IDX_BCNT: begin
          err_r <= err_nxt;
          ok_r <= is_write && err_nxt == mbtcp_pkg::EXC_NONE;
        end
        mbtcp_pkg::IDX_DATA: begin
          hi_r <= i_rx.data;
          dcnt_r <= dcnt_r + 8'h01;
        end
        default: msg_r <= {msg_r[23:0], i_rx.data};
      endcase
      if (idx_r >= mbtcp_pkg::IDX_STATION) begin
        rem_r <= rem_r - 16'h0001;
      end
      if (frame_end) begin
        idx_r <= 4'h0;
        dcnt_r <= 8'h00;
        ok_r <= 1'b0;
        err_r <= mbtcp_pkg::EXC_VALUE;
      end
    end
  end

  // -------------------------------------------------------------------
  // stores: word lands on its low byte; a word pair of a 32-bit value
  // arrives low word first, so addresses simply ascend
  // -------------------------------------------------------------------
  logic wr_word;
  logic [15:0] wr_addr, wr_data;
  logic [15:0] idle_inc, dog_eff, tcp_eff, sys_eff;
  logic sec_pulse, dog_fire, tcp_fire, sys_fire;

  assign wr_word = take && ok_r && idx_r == mbtcp_pkg::IDX_DATA &&
                   fc_r == mbtcp_pkg::FC_WRITE_REGS && dcnt_r[0];
  assign wr_addr = addr_r + {9'h000, dcnt_r[7:1]};
  assign wr_data = {hi_r, i_rx.data};

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cause_r <= 16'h0000;
      cap_done_r <= 1'b0;
      dog_r <= 16'h0000;
      events_r <= 16'h0000;
      tcp_r <= 16'h0000;
      sys_r <= 16'h0000;
      o_flash_store <= 1'b0;
    end else begin
      cap_done_r <= 1'b1;
      if (!cap_done_r) begin
        cause_r <= i_reset_cause;
      end
      o_flash_store <= 1'b0;
      if (wr_word) begin
        unique case (wr_addr)
          mbtcp_pkg::HR_RESET_CAUSE: cause_r <= wr_data;
          mbtcp_pkg::HR_DOG_PERIOD: dog_r <= wr_data;
          mbtcp_pkg::HR_TCP_IDLE_TIMEOUT: tcp_r <= wr_data;
          mbtcp_pkg::HR_SYS_TIMEOUT: sys_r <= wr_data;
          default: ;
        endcase
        o_flash_store <= wr_addr == mbtcp_pkg::HR_DOG_PERIOD ||
                         wr_addr == mbtcp_pkg::HR_TCP_IDLE_TIMEOUT ||
                         wr_addr == mbtcp_pkg::HR_SYS_TIMEOUT;
      end
      // a software write and an event in one cycle both count
      if (wr_word && wr_addr == mbtcp_pkg::HR_DOG_EVENTS) begin
        events_r <= wr_data + {15'h0000, dog_fire};
      end else if (dog_fire) begin
        events_r <= events_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_restore_web <= 1'b0;
      o_restore_identity <= 1'b0;
      o_reboot <= 1'b0;
    end else begin
      o_restore_web <= 1'b0;
      o_restore_identity <= 1'b0;
      o_reboot <= 1'b0;
      if (take && ok_r && idx_r == mbtcp_pkg::IDX_DATA &&
          fc_r == mbtcp_pkg::FC_WRITE_COILS && i_rx.data[0]) begin
        o_restore_web <= addr_r == mbtcp_pkg::COIL_RESTORE_WEB;
        o_restore_identity <= addr_r == mbtcp_pkg::COIL_RESTORE_ID;
        o_reboot <= addr_r == mbtcp_pkg::COIL_REBOOT;
      end
    end
  end

  // -------------------------------------------------------------------
  // idle timers: one seconds prescaler shared by all three
  // -------------------------------------------------------------------
  logic good_frame;
  assign good_frame = frame_end && station_ok;
  assign sec_pulse = pre_r == SEC_CYCLES - 1;
  assign idle_inc = idle_r + 16'h0001;
  assign dog_eff = effective(dog_r, mbtcp_pkg::DOG_MIN, DOG_DEFAULT);
  assign tcp_eff = effective(tcp_r, mbtcp_pkg::TCP_MIN, TCP_DEFAULT);
  assign sys_eff = effective(sys_r, mbtcp_pkg::SYS_MIN, SYS_DEFAULT);
  assign dog_fire = sec_pulse && dog_eff != 16'h0000 &&
                    idle_inc == dog_eff;
  assign tcp_fire = sec_pulse && tcp_eff != 16'h0000 &&
                    idle_inc == tcp_eff;
  assign sys_fire = sec_pulse && sys_eff != 16'h0000 &&
                    idle_inc == sys_eff;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pre_r <= 32'h0000_0000;
      idle_r <= 16'h0000;
      comm_r <= mbtcp_pkg::COMM_OK;
      o_safe_outputs <= 1'b0;
      o_tcp_idle_timeout <= 1'b0;
      o_system_timeout <= 1'b0;
    end else begin
      pre_r <= (sec_pulse || good_frame) ? 32'h0000_0000 :
               pre_r + 32'h0000_0001;
      if (good_frame) begin
        idle_r <= 16'h0000;
      end else if (sec_pulse && idle_r != 16'hFFFF) begin
        idle_r <= idle_inc;
      end
      // loss of the host wins over a frame ending in the same cycle
      if (dog_fire || tcp_fire) begin
        comm_r <= mbtcp_pkg::COMM_TIMEOUT;
      end else if (good_frame) begin
        comm_r <= mbtcp_pkg::COMM_OK;
      end
      if (dog_fire) begin
        o_safe_outputs <= 1'b1;
      end else if (good_frame) begin
        o_safe_outputs <= 1'b0;
      end
      o_tcp_idle_timeout <= tcp_fire;
      o_system_timeout <= sys_fire;
    end
  end

  // -------------------------------------------------------------------
  // reply
  // -------------------------------------------------------------------
  function automatic logic [7:0] resp_byte(input logic [3:0] i);
    logic [15:0] plen;
    plen = {12'h000, tx_last} - {12'h000, mbtcp_pkg::IDX_LEN_LO};
    unique case (i)
      4'h0: resp_byte = msg_r[31:24];
      4'h1: resp_byte = msg_r[23:16];
      4'h2: resp_byte = msg_r[15:8];
      4'h3: resp_byte = msg_r[7:0];
      mbtcp_pkg::IDX_LEN_HI: resp_byte = plen[15:8];
      mbtcp_pkg::IDX_LEN_LO: resp_byte = plen[7:0];
      mbtcp_pkg::IDX_STATION: resp_byte = station_r;
      mbtcp_pkg::IDX_FC: resp_byte = (exc_r != mbtcp_pkg::EXC_NONE) ?
          (fc_r | mbtcp_pkg::FC_EXC_FLAG) : fc_r;
      mbtcp_pkg::IDX_ADDR_HI: begin
        if (exc_r != mbtcp_pkg::EXC_NONE) begin
          resp_byte = exc_r;
        end else begin
          resp_byte = is_read ? mbtcp_pkg::READ_BCNT : addr_r[15:8];
        end
      end
      mbtcp_pkg::IDX_ADDR_LO: resp_byte = is_read ? rdval_r[15:8] :
          addr_r[7:0];
      mbtcp_pkg::IDX_CNT_HI: resp_byte = is_read ? rdval_r[7:0] :
          count_r[15:8];
      default: resp_byte = count_r[7:0];
    endcase
  endfunction : resp_byte

  assign tx_last = (exc_r != mbtcp_pkg::EXC_NONE) ? mbtcp_pkg::IDX_EXC_LAST :
                   is_read ? mbtcp_pkg::IDX_READ_LAST :
                   mbtcp_pkg::IDX_WRITE_LAST;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= mbtcp_pkg::ST_RECV;
      o_rx_ready <= 1'b1;
      o_tx <= '0;
      txi_r <= 4'h0;
      exc_r <= mbtcp_pkg::EXC_NONE;
      rdval_r <= 16'h0000;
    end else if (state_r == mbtcp_pkg::ST_RECV) begin
      if (good_frame) begin
        state_r <= mbtcp_pkg::ST_SEND;
        o_rx_ready <= 1'b0;
        exc_r <= exc_nxt;
        rdval_r <= rd_hit[15:0];
        txi_r <= 4'h0;
        o_tx.valid <= 1'b1;
        o_tx.last <= 1'b0;
        o_tx.data <= msg_r[31:24];
      end
    end else if (o_tx.valid && i_tx_ready) begin
      if (txi_r == tx_last) begin
        state_r <= mbtcp_pkg::ST_RECV;
        o_rx_ready <= 1'b1;
        o_tx <= '0;
      end else begin
        txi_r <= txi_r + 4'h1;
        o_tx.data <= resp_byte(txi_r + 4'h1);
        o_tx.last <= (txi_r + 4'h1) == tx_last;
      end
    end
  end

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  sequence s_good_end;
    frame_end && station_ok;
  endsequence
  sequence s_tx_byte(logic [3:0] k);
    o_tx.valid && txi_r == k;
  endsequence

  a_end_starts_reply: assert property (@(posedge i_clk)
    disable iff (!i_resetn) s_good_end |=> o_tx.valid && !o_rx_ready &&
      o_tx.data == msg_r[31:24])
    else $error("reply did not start after a good frame");
  a_bad_station_quiet: assert property (@(posedge i_clk)
    disable iff (!i_resetn) frame_end && !station_ok |=> !o_tx.valid)
    else $error("reply sent for a station outside 1..247");
  a_fc_echo: assert property (@(posedge i_clk)
    disable iff (!i_resetn) s_tx_byte(mbtcp_pkg::IDX_FC) &&
      exc_r == mbtcp_pkg::EXC_NONE |-> o_tx.data == fc_r)
    else $error("function code not echoed");
  a_exc_fc_flag: assert property (@(posedge i_clk)
    disable iff (!i_resetn) s_tx_byte(mbtcp_pkg::IDX_FC) &&
      exc_r != mbtcp_pkg::EXC_NONE |->
      o_tx.data == (fc_r | mbtcp_pkg::FC_EXC_FLAG) &&
      tx_last == mbtcp_pkg::IDX_EXC_LAST)
    else $error("exception reply malformed");
  a_addr_echo: assert property (@(posedge i_clk)
    disable iff (!i_resetn) s_tx_byte(mbtcp_pkg::IDX_ADDR_LO) &&
      exc_r == mbtcp_pkg::EXC_NONE && is_write |-> o_tx.data == addr_r[7:0])
    else $error("start address not echoed");
  a_tx_held: assert property (@(posedge i_clk)
    disable iff (!i_resetn) o_tx.valid && !i_tx_ready |=>
      o_tx.valid && $stable(o_tx.data) && $stable(txi_r))
    else $error("reply byte changed while stalled");
  a_store_guard: assert property (@(posedge i_clk)
    disable iff (!i_resetn) wr_word |-> err_r == mbtcp_pkg::EXC_NONE &&
      hr_writable(wr_addr))
    else $error("register stored after a failed check");
  a_coil_pulse: assert property (@(posedge i_clk)
    disable iff (!i_resetn) o_reboot |=> !o_reboot ##1 state_r ==
      mbtcp_pkg::ST_SEND || !o_reboot)
    else $error("reboot pulse longer than one cycle");
  a_dog_safe: assert property (@(posedge i_clk)
    disable iff (!i_resetn) dog_fire |=> o_safe_outputs &&
      comm_r == mbtcp_pkg::COMM_TIMEOUT && events_r != $past(events_r))
    else $error("watchdog expiry not acted on");

endmodule : modbus_tcp_register_slave

// ---- verilog/mbtcp_pkg.sv ----
// constants, types and field layout for the register-write frame server
// How it works
// - accept function 0x10 from stations 1..247
// - sixteen-bit values travel high byte first
// - 32-bit values: low word first, bytes high-first
// - success reply echoes station, function, address, count
// - failure reply: station, 0x90, exception code
// - six-byte header; message number echoed back
// - coils 127/128 pulse web/identity default restore
// - coil 133 pulses a module reboot
// - input register 151 returns firmware version
// - input register 158: 0 ok, 1 timeout
// - input register 160: normal/timeout/disconnected
// - holding register 255 holds last reset cause
// - register 257 host watchdog; expiry forces safe outputs
// - register 258 counts host watchdog events
// - register 263 Tcp_idle_timeout seconds, below 5 off; code takes 0 as the 180 s default
// - register 264 system timeout, below 30 off; code takes 0 as the 120 s default
// - watchdog period and timeouts go to flash
package mbtcp_pkg;

  // -------------------------------------------------------------------
  // function and exception codes
  // -------------------------------------------------------------------
  localparam logic [7:0] FC_READ_HOLD = 8'h03;
  localparam logic [7:0] FC_READ_INPUT = 8'h04;
  localparam logic [7:0] FC_WRITE_COILS = 8'h0F;
  localparam logic [7:0] FC_WRITE_REGS = 8'h10;
  localparam logic [7:0] FC_EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [7:0] STATION_MIN = 8'h01;
  localparam logic [7:0] STATION_MAX = 8'hF7;
  localparam logic [15:0] MAX_WRITE_REGS = 16'h007B;

  // -------------------------------------------------------------------
  // byte positions from frame start (header is six bytes)
  // -------------------------------------------------------------------
  localparam logic [3:0] IDX_LEN_HI = 4'h4;
  localparam logic [3:0] IDX_LEN_LO = 4'h5;
  localparam logic [3:0] IDX_STATION = 4'h6;
  localparam logic [3:0] IDX_FC = 4'h7;
  localparam logic [3:0] IDX_ADDR_HI = 4'h8;
  localparam logic [3:0] IDX_ADDR_LO = 4'h9;
  localparam logic [3:0] IDX_CNT_HI = 4'hA;
  localparam logic [3:0] IDX_CNT_LO = 4'hB;
  localparam logic [3:0] IDX_BCNT = 4'hC;
  localparam logic [3:0] IDX_DATA = 4'hD;
  localparam logic [3:0] IDX_EXC_LAST = 4'h8;
  localparam logic [3:0] IDX_READ_LAST = 4'hA;
  localparam logic [3:0] IDX_WRITE_LAST = 4'hB;
  localparam logic [15:0] READ_PDU_LEN = 16'h0006;
  localparam logic [15:0] WRITE_FIXED_LEN = 16'h0007;
  localparam logic [7:0] READ_BCNT = 8'h02;

  // -------------------------------------------------------------------
  // coil, input and holding register addresses
  // -------------------------------------------------------------------
  localparam logic [15:0] COIL_RESTORE_WEB = 16'h007F;
  localparam logic [15:0] COIL_RESTORE_ID = 16'h0080;
  localparam logic [15:0] COIL_REBOOT = 16'h0085;
  localparam logic [15:0] IR_FW_VERSION = 16'h0097;
  localparam logic [15:0] IR_COMM_STATUS = 16'h009E;
  localparam logic [15:0] IR_PAIR_STATUS = 16'h00A0;
  localparam logic [15:0] HR_RESET_CAUSE = 16'h00FF;
  localparam logic [15:0] HR_DOG_PERIOD = 16'h0101;
  localparam logic [15:0] HR_DOG_EVENTS = 16'h0102;
  localparam logic [15:0] HR_MODULE_ID = 16'h0103;
  localparam logic [15:0] HR_TCP_IDLE_TIMEOUT = 16'h0107;
  localparam logic [15:0] HR_SYS_TIMEOUT = 16'h0108;

  // -------------------------------------------------------------------
  // values, limits and timing
  // -------------------------------------------------------------------
  localparam logic [15:0] COMM_OK = 16'h0000;
  localparam logic [15:0] COMM_TIMEOUT = 16'h0001;
  localparam logic [15:0] DOG_MIN = 16'h0005;
  localparam logic [15:0] TCP_MIN = 16'h0005;
  localparam logic [15:0] SYS_MIN = 16'h001E;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned SECOND_NS = 1000000000;
  localparam int unsigned SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } byte_stream_type;

  typedef enum logic {
    ST_RECV = 1'b0,
    ST_SEND = 1'b1
  } state_type;

endpackage : mbtcp_pkg

// ---- tb/mb_client.sv ----
// modbus client host model: sends request frames, collects replies
`timescale 1ns/1ps
module mb_client (
  // clock
  input wire logic i_clk,
  // server side
  input wire logic i_rdy,
  input wire mbtcp_pkg::byte_stream_type i_rep,
  output mbtcp_pkg::byte_stream_type o_req,
  output logic o_take
);
  logic [7:0] rsp[$];
  initial begin
    o_req = '0;
    o_take = 1'b0;
  end
  // whole frame, header first, every field msb first
  task automatic put(input logic [7:0] f[$], input bit slow);
    rsp = {};
    @(posedge i_clk);
    foreach (f[i]) begin
      #1 o_req = '{1'b1, i == f.size() - 1, f[i]};
      do @(posedge i_clk); while (!i_rdy);
    end
    // released line must not keep showing the last byte
    #1 o_req = '{1'b0, 1'b0, ~o_req.data};
    o_take = 1'b1;
    repeat (200) begin
      @(posedge i_clk);
      if (i_rep.valid && o_take) rsp.push_back(i_rep.data);
      if (i_rep.valid && o_take && i_rep.last) break;
      #1 o_take = slow ? !o_take : 1'b1;
    end
    #1 o_take = 1'b0;
  endtask : put
endmodule : mb_client

// ---- tb/test_modbus_tcp_register_slave.sv ----
// bench for the register-write frame server
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  mismatches++; $display("BAD %s exp %h got %h", nm, e, g); end end
module test_modbus_tcp_register_slave;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_tx_ready, o_rx_ready, o_rw, o_ri, o_rb, o_fs, o_so, o_tt, o_st;
  mbtcp_pkg::byte_stream_type i_rx, o_tx;
  int mismatches = 0;
  int n_tests = 0;
  int pc[6] = '{0, 0, 0, 0, 0, 0};
  typedef logic [7:0] bq_type[$];
  always #10 i_clk = ~i_clk;
  always @(posedge i_clk) pc <= '{pc[0] + o_rw, pc[1] + o_ri,
    pc[2] + o_rb, pc[3] + o_fs, pc[4] + o_tt, pc[5] + o_st};
  // short second keeps watchdog expiry near 200 cycles
  modbus_tcp_register_slave #(.SEC_CYCLES(20)) DUT (.i_clk, .i_resetn,
    .i_rx, .o_rx_ready, .o_tx, .i_tx_ready, .i_reset_cause(16'h0001),
    .i_pair_status(16'h0002), .o_restore_web(o_rw),
    .o_restore_identity(o_ri), .o_reboot(o_rb), .o_flash_store(o_fs),
    .o_safe_outputs(o_so), .o_tcp_idle_timeout(o_tt), .o_system_timeout(o_st));
  mb_client HOST (.i_clk, .i_rdy(o_rx_ready), .i_rep(o_tx),
    .o_req(i_rx), .o_take(i_tx_ready));
  function automatic bq_type fr(bq_type p);
    return {8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'(p.size()), p};
  endfunction : fr
  task automatic xc(bq_type rq, bq_type ex, bit slow);
    bq_type e;
    e = fr(ex);
    HOST.put(fr(rq), slow);
    `CHK("len", e.size(), HOST.rsp.size())
    foreach (e[i]) `CHK("byte", e[i], HOST.rsp[i])
  endtask : xc
  task automatic sc_write();
    xc('{1, 8'h10, 1, 7, 0, 1, 2, 0, 8'h3C}, '{1, 8'h10, 1, 7, 0, 1}, 1);
    `CHK("flash", 1, pc[3])
    xc('{1, 8'h10, 1, 7, 0, 2, 4, 8'h0C, 8'h0D, 8'h0A, 8'h0B},
      '{1, 8'h10, 1, 7, 0, 2}, 0);
  endtask : sc_write
  task automatic sc_bad();
    xc('{1, 8'h10, 1, 8, 0, 1, 3, 0, 1, 2}, '{1, 8'h90, 3}, 0);
    xc('{1, 6, 1, 8, 0, 8'h3C}, '{1, 8'h86, 1}, 0);
    xc('{1, 8'h10, 1, 3, 0, 1, 2, 0, 1}, '{1, 8'h90, 2}, 0);
    xc('{1, 3, 1, 7, 0, 2}, '{1, 8'h83, 3}, 0);
  endtask : sc_bad
  task automatic sc_coils();
    logic [7:0] a[3] = '{8'h7F, 8'h80, 8'h85};
    for (int i = 0; i < 3; i++) begin
      xc('{1, 8'h0F, 0, a[i], 0, 1, 1, 1}, '{1, 8'h0F, 0, a[i], 0, 1}, 0);
      `CHK("coil", 1, pc[i])
    end
  endtask : sc_coils
  task automatic sc_reads();
    logic [7:0] f[5] = '{4, 4, 3, 3, 3};
    logic [15:0] a[5] = '{16'h0097, 16'h00A0, 16'h00FF, 16'h0107, 16'h0108};
    logic [15:0] v[5] = '{16'h007B, 16'h0002, 16'h0001, 16'h0C0D, 16'h0A0B};
    for (int i = 0; i < 5; i++)
      xc('{1, f[i], a[i][15:8], a[i][7:0], 0, 1},
        '{1, f[i], 2, v[i][15:8], v[i][7:0]}, 0);
  endtask : sc_reads
  task automatic sc_dog();
    // station 0 is ignored, so the host watchdog keeps running
    HOST.put(fr('{0, 4, 0, 8'h97, 0, 1}), 0);
    `CHK("quiet", 0, HOST.rsp.size())
    repeat (30) @(posedge i_clk);
    `CHK("safe", 1'b1, o_so)
    xc('{1, 4, 0, 8'h9E, 0, 1}, '{1, 4, 2, 0, 1}, 0);
    `CHK("safe", 1'b0, o_so)
    xc('{1, 3, 1, 2, 0, 1}, '{1, 3, 2, 0, 1}, 0);
  endtask : sc_dog
  task automatic sc_timers();
    xc('{1, 8'h10, 1, 7, 0, 2, 4, 0, 5, 0, 8'h1E},
      '{1, 8'h10, 1, 7, 0, 2}, 0);
    `CHK("flash", 5, pc[3])
    repeat (620) @(posedge i_clk);
    `CHK("tcp", 1, pc[4])
    `CHK("sys", 1, pc[5])
  endtask : sc_timers
  task automatic print_verdict();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (4) @(posedge i_clk);
    #1 i_resetn = 1'b1;
    sc_write();
    sc_bad();
    sc_coils();
    sc_reads();
    sc_dog();
    sc_timers();
    print_verdict();
  end
  // hang guard, a few times the expected run
  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end
endmodule : test_modbus_tcp_register_slave
